/* hdl/iwd_pkg.sv */
// Shared constants for the I/O port watchdog timer.
package iwd_pkg;

    // ****************************************
    // I/O port map
    // ****************************************
    localparam logic [15:0] IWD_ARM_PORT = 16'h0443;
    localparam logic [15:0] IWD_DISARM_PORT = 16'h0441;
    localparam int IWD_IO_WIDTH = 16;

    // ****************************************
    // Interval code layout
    // ****************************************
    localparam int IWD_CODE_LSB = 0;
    localparam int IWD_CODE_WIDTH = 4;
    localparam logic [3:0] IWD_CODE_MAX = 4'hF;
    localparam int IWD_STEP_S = 2;
    localparam int IWD_MAX_S = 30;
    localparam int IWD_SEC_WIDTH = 5;

    // ****************************************
    // Timing
    // ****************************************
    localparam int IWD_CLK_PERIOD_NS = 4;
    localparam int IWD_NS_PER_S = 32'h3B9A_CA00;
    localparam int IWD_CYCLES_PER_S = IWD_NS_PER_S / IWD_CLK_PERIOD_NS;
    localparam int IWD_RST_PULSE_NS = 32'h0000_03E8;
    localparam int IWD_RST_PULSE_CYCLES =
        (IWD_RST_PULSE_NS + IWD_CLK_PERIOD_NS - 1) / IWD_CLK_PERIOD_NS;

    // ****************************************
    // States
    // ****************************************
    typedef enum logic [1:0] {
        IWD_IDLE = 2'b00,
        IWD_RUN = 2'b01,
        IWD_FIRE = 2'b10
    } iwd_state_t;

endpackage

/* hdl/iwd_tick.sv */
// One-second tick generator that restarts on request.
`timescale 1ns/1ps
`default_nettype none
module iwd_tick #(
    parameter int CYCLES = iwd_pkg::IWD_CYCLES_PER_S
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic clear_in,
    output logic tick_out
);
    generate
        if (CYCLES < 1) begin : g_bad
            $error("iwd_tick: CYCLES must be at least one");
        end
    endgenerate

    logic [31:0] cnt_q;
    logic [31:0] cnt_d;
    logic tick_q;
    logic tick_d;

    always_comb begin
        cnt_d = cnt_q + 32'h0000_0001;
        tick_d = 1'b0;
        if (clear_in) begin
            cnt_d = 32'h0000_0000;
        end else if (cnt_q == 32'(CYCLES - 1)) begin
            cnt_d = 32'h0000_0000;
            tick_d = 1'b1;
        end
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            cnt_q <= 32'h0000_0000;
            tick_q <= 1'b0;
        end else begin
            cnt_q <= cnt_d;
            tick_q <= tick_d;
        end
    end

    assign tick_out = tick_q;
endmodule
`default_nettype wire

/* hdl/iwd_top.sv */
// I/O port watchdog timer: arm, disarm and system reset generation.
// What this block does
// - Expired armed interval asserts system reset.
// - Arm port write enables with written code.
// - Any write to disarm port stops watchdog.
// - Code F is 0 s, each step down +2 s.
// - Interval error stays within twenty percent.
`timescale 1ns/1ps
`default_nettype none
module iwd_top #(
    parameter int CYCLES_PER_S = iwd_pkg::IWD_CYCLES_PER_S,
    parameter int RST_PULSE_CYCLES = iwd_pkg::IWD_RST_PULSE_CYCLES
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] io_addr_in,
    input wire logic [15:0] io_data_in,
    input wire logic io_wr_n_in,
    output logic sys_rst_n_out,
    output logic armed_out,
    output logic [4:0] secs_left_out
);
    // ****************************************
    // Local widths
    // ****************************************
    // The pulse counter is sized for a microsecond class pulse at any sane
    // clock; a much longer pulse needs a wider counter.
    localparam int PULSE_W = 16;
    localparam int PULSE_MAX = (1 << PULSE_W) - 1;
    localparam int SEC_W = iwd_pkg::IWD_SEC_WIDTH;

    // ****************************************
    // Elaboration checks
    // ****************************************
    generate
        if (CYCLES_PER_S < 1) begin : g_bad_sec
            $error("iwd_top: CYCLES_PER_S must be at least one");
        end
        if (RST_PULSE_CYCLES < 1 || RST_PULSE_CYCLES > PULSE_MAX) begin : g_bad_pulse
            $error("iwd_top: RST_PULSE_CYCLES does not fit the pulse counter");
        end
        if (iwd_pkg::IWD_CODE_LSB + iwd_pkg::IWD_CODE_WIDTH >
                iwd_pkg::IWD_IO_WIDTH) begin : g_bad_code
            $error("iwd_top: interval code field lies outside the I/O word");
        end
        if (iwd_pkg::IWD_MAX_S >= (1 << SEC_W)) begin : g_bad_secw
            $error("iwd_top: longest interval does not fit the seconds counter");
        end
        if (iwd_pkg::IWD_MAX_S != int'(iwd_pkg::IWD_CODE_MAX) * iwd_pkg::IWD_STEP_S) begin : g_bad_tab
            $error("iwd_top: interval table does not end at the longest interval");
        end
        if (SEC_W != $bits(secs_left_out)) begin : g_bad_port
            $error("iwd_top: seconds width must match the status port");
        end
    endgenerate

    // ****************************************
    // Bus pin synchronisers
    // ****************************************
    // The host bus is asynchronous, so address and data pass two and the strobe three
    // flops. A write is taken on the falling edge of the synchronised strobe;
    // the bus holds address and data well beyond the strobe edge, which
    // covers the skew between the bit synchronisers.
    // The strobe flops reset high, the idle level of the pin, so releasing
    // reset never looks like a falling strobe.
    logic [15:0] addr_s1_q, addr_s2_q, addr_s1_d, addr_s2_d;
    logic [15:0] data_s1_q, data_s2_q, data_s1_d, data_s2_d;
    logic wr_s1_q, wr_s2_q, wr_s3_q, wr_s1_d, wr_s2_d, wr_s3_d;

    always_comb begin
        addr_s1_d = io_addr_in;
        addr_s2_d = addr_s1_q;
        data_s1_d = io_data_in;
        data_s2_d = data_s1_q;
        wr_s1_d = io_wr_n_in;
        wr_s2_d = wr_s1_q;
        wr_s3_d = wr_s2_q;
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            addr_s1_q <= 16'h0000;
            addr_s2_q <= 16'h0000;
            data_s1_q <= 16'h0000;
            data_s2_q <= 16'h0000;
            wr_s1_q <= 1'b1;
            wr_s2_q <= 1'b1;
            wr_s3_q <= 1'b1;
        end else begin
            addr_s1_q <= addr_s1_d;
            addr_s2_q <= addr_s2_d;
            data_s1_q <= data_s1_d;
            data_s2_q <= data_s2_d;
            wr_s1_q <= wr_s1_d;
            wr_s2_q <= wr_s2_d;
            wr_s3_q <= wr_s3_d;
        end
    end

    // ****************************************
    // Write decode
    // ****************************************
    logic wr_take;
    logic arm_wr;
    logic disarm_wr;
    logic [3:0] code;
    logic [4:0] load_secs;

    assign wr_take = wr_s3_q && !wr_s2_q;
    assign arm_wr = wr_take && (addr_s2_q == iwd_pkg::IWD_ARM_PORT);
    assign disarm_wr = wr_take && (addr_s2_q == iwd_pkg::IWD_DISARM_PORT);
    // Bits above the code field are ignored.
    assign code = data_s2_q[iwd_pkg::IWD_CODE_LSB +: iwd_pkg::IWD_CODE_WIDTH];
    // Code F maps to zero seconds and each lower code adds one step.
    assign load_secs = 5'((iwd_pkg::IWD_CODE_MAX - code) * iwd_pkg::IWD_STEP_S);

    // ****************************************
    // Seconds base
    // ****************************************
    // The base restarts on every arm so the first second is whole; the
    // interval then runs two clock cycles over the whole seconds, far inside the tolerance.
    logic sec_tick;

    iwd_tick #(
        .CYCLES(CYCLES_PER_S)
    ) u_tick (
        .clk_in(clk_in),
        .rst_n_in(rst_n_in),
        .clear_in(arm_wr),
        .tick_out(sec_tick)
    );

    // ****************************************
    // Watchdog state machine
    // ****************************************
    iwd_pkg::iwd_state_t state_q, state_d;
    logic [4:0] secs_q, secs_d;
    logic [PULSE_W-1:0] pulse_q, pulse_d;
    logic sys_rst_n_q, sys_rst_n_d;
    logic armed_q, armed_d;

    always_comb begin
        state_d = state_q;
        secs_d = secs_q;
        pulse_d = pulse_q;
        sys_rst_n_d = 1'b1;
        case (state_q)
            iwd_pkg::IWD_IDLE: begin
                // A disarm while idle has nothing to stop and is dropped.
                if (arm_wr) begin
                    state_d = iwd_pkg::IWD_RUN;
                    secs_d = load_secs;
                end
            end
            iwd_pkg::IWD_RUN: begin
                // Disarm is tested first so that a service write landing in the
                // last cycle still stops the pulse; arm and disarm never meet in
                // one cycle because both come from the one strobe.
                if (disarm_wr) begin
                    state_d = iwd_pkg::IWD_IDLE;
                    secs_d = 5'h00;
                end else if (arm_wr) begin
                    secs_d = load_secs;
                end else if (secs_q == 5'h00) begin
                    state_d = iwd_pkg::IWD_FIRE;
                    pulse_d = 16'(RST_PULSE_CYCLES - 1);
                    sys_rst_n_d = 1'b0;
                end else if (sec_tick) begin
                    secs_d = secs_q - 5'h01;
                end
            end
            iwd_pkg::IWD_FIRE: begin
                // The pulse runs to its end; host writes are meaningless while
                // the system is being reset.
                // After the pulse the block is disarmed, so software must arm it
                // again once the system is back.
                sys_rst_n_d = 1'b0;
                if (pulse_q == 16'h0000) begin
                    state_d = iwd_pkg::IWD_IDLE;
                    sys_rst_n_d = 1'b1;
                end else begin
                    pulse_d = pulse_q - 16'h0001;
                end
            end
            default: begin
                // An unknown state code drops back to idle without a pulse.
                state_d = iwd_pkg::IWD_IDLE;
                secs_d = 5'h00;
                pulse_d = 16'h0000;
            end
        endcase
        // The status pin is registered from the next state, so it moves on
        // the same edge as the state itself.
        armed_d = (state_d == iwd_pkg::IWD_RUN);
    end

    always_ff @(posedge clk_in) begin
        if (!rst_n_in) begin
            state_q <= iwd_pkg::IWD_IDLE;
            secs_q <= 5'h00;
            pulse_q <= 16'h0000;
            sys_rst_n_q <= 1'b1;
            armed_q <= 1'b0;
        end else begin
            state_q <= state_d;
            secs_q <= secs_d;
            pulse_q <= pulse_d;
            sys_rst_n_q <= sys_rst_n_d;
            armed_q <= armed_d;
        end
    end

    // ****************************************
    // Outputs
    // ****************************************
    // The seconds count reads zero while idle and while the pulse runs, so
    // software cannot mistake a spent interval for a running one.
    assign sys_rst_n_out = sys_rst_n_q;
    assign armed_out = armed_q;
    assign secs_left_out = secs_q;
endmodule
`default_nettype wire

/* verif/iwd_top_monitor.sv */
// Port-level checker for the I/O port watchdog timer.
`timescale 1ns/1ps
`default_nettype none
module iwd_top_monitor #(
    parameter int CYCLES_PER_S = 10,
    parameter int RST_PULSE_CYCLES = 4
) (
    input wire logic clk_in,
    input wire logic rst_n_in,
    input wire logic [15:0] io_addr_in,
    input wire logic [15:0] io_data_in,
    input wire logic io_wr_n_in,
    input wire logic sys_rst_n_out,
    input wire logic armed_out,
    input wire logic [4:0] secs_left_out
);
    // ****************************************
    // Properties
    // ****************************************
    default clocking @(posedge clk_in); endclocking
    default disable iff (!rst_n_in);
    logic [7:0] lo_cnt_q;
    logic [7:0] lo_cnt_d;
    // A counter keeps the pulse length exact without a long repetition.
    always_comb lo_cnt_d = sys_rst_n_out ? 8'h00 : lo_cnt_q + 8'h01;
    always_ff @(posedge clk_in) lo_cnt_q <= rst_n_in ? lo_cnt_d : 8'h00;
    a_reset_idle: assert property (disable iff (1'b0) !rst_n_in |=>
        sys_rst_n_out && !armed_out && secs_left_out == 5'h00) else $error("reset state");
    a_fire_at_zero: assert property (armed_out && secs_left_out == 5'h00 |->
        ##[1:2] !sys_rst_n_out) else $error("no reset at zero");
    a_pulse_len: assert property ($rose(sys_rst_n_out) |->
        lo_cnt_q == 8'(RST_PULSE_CYCLES)) else $error("pulse length");
    a_idle_in_fire: assert property (!sys_rst_n_out |-> !armed_out)
        else $error("armed in pulse");
    a_fire_needs_arm: assert property ($fell(sys_rst_n_out) |-> $past(armed_out))
        else $error("unarmed reset");
    a_arm_loads_code: assert property ($fell(io_wr_n_in) && io_addr_in == 16'h0443
        && sys_rst_n_out |-> ##[3:5] armed_out
        && secs_left_out == {4'hF - io_data_in[3:0], 1'b0}) else $error("arm load");
    a_disarm_stops: assert property ($fell(io_wr_n_in) && io_addr_in == 16'h0441
        |-> ##[3:5] !armed_out) else $error("disarm");
    a_other_ignored: assert property ($fell(io_wr_n_in) && !armed_out && sys_rst_n_out
        && io_addr_in != 16'h0443 |=> !armed_out [*6]) else $error("stray arm");
    c_fire: cover property ($fell(sys_rst_n_out));
    c_rearm: cover property (armed_out && $fell(io_wr_n_in) && io_addr_in == 16'h0443);
    c_disarm: cover property ($fell(armed_out) && sys_rst_n_out);
endmodule
bind iwd_top iwd_top_monitor #(.CYCLES_PER_S(CYCLES_PER_S), .RST_PULSE_CYCLES(RST_PULSE_CYCLES))
    iwd_top_monitor_inst (.clk_in(clk_in), .rst_n_in(rst_n_in), .io_addr_in(io_addr_in),
    .io_data_in(io_data_in), .io_wr_n_in(io_wr_n_in), .sys_rst_n_out(sys_rst_n_out),
    .armed_out(armed_out), .secs_left_out(secs_left_out));
`default_nettype wire

/* verif/iwd_top_tb_top.sv */
// Self-checking bench for the I/O port watchdog timer.
`timescale 1ns/1ps
`default_nettype none
module iwd_top_tb_top;
    // ****************************************
    // Bench
    // ****************************************
    localparam int RPC = 4;
    // Cycles from an arm taking effect to the return of io_write.
    localparam int WR_LAG = 3;
    logic clk_in = 1'b0;
    logic rst_n_in = 1'b0;
    logic [15:0] io_addr_in = 16'h0000;
    logic [15:0] io_data_in = 16'h0000;
    logic io_wr_n_in = 1'b1;
    logic sys_rst_n_out;
    logic armed_out;
    logic [4:0] secs_left_out;
    int n_mismatch = 0;
    int checks = 0;
    initial begin
        forever #2 clk_in = ~clk_in;
    end
    iwd_top #(.CYCLES_PER_S(10), .RST_PULSE_CYCLES(RPC)) iwd_top_inst (.clk_in(clk_in),
        .rst_n_in(rst_n_in), .io_addr_in(io_addr_in), .io_data_in(io_data_in),
        .io_wr_n_in(io_wr_n_in), .sys_rst_n_out(sys_rst_n_out), .armed_out(armed_out),
        .secs_left_out(secs_left_out));
    task automatic check(string what, logic [7:0] exp, logic [7:0] got);
        checks++;
        if (got !== exp) begin
            n_mismatch++;
            $display("MISMATCH %s expected %h seen %h", what, exp, got);
        end
    endtask
    task automatic step(int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask
    // Address and data stay put after the strobe so the take edge never sees them move.
    task automatic io_write(logic [15:0] addr, logic [15:0] data);
        @(posedge clk_in);
        io_addr_in <= addr;
        io_data_in <= data;
        io_wr_n_in <= 1'b0;
        repeat (3) @(posedge clk_in);
        io_wr_n_in <= 1'b1;
        step(3);
    endtask
    task automatic wait_level(logic lvl, output int n);
        n = 0;
        while (sys_rst_n_out !== lvl && n < 1000) begin
            step(1);
            n++;
        end
        check("wait limit", 8'h01, 8'(n < 1000));
    endtask
    task automatic t_expire();
        int n;
        io_write(iwd_pkg::IWD_ARM_PORT, 16'h000E);
        check("armed", 8'h01, 8'(armed_out));
        check("secs E", 8'h02, 8'(secs_left_out));
        wait_level(1'b0, n);
        check("interval", 8'h01, 8'(n + WR_LAG >= 16 && n + WR_LAG <= 24));
        wait_level(1'b1, n);
        check("pulse", 8'(RPC), 8'(n));
    endtask
    task automatic t_code_f();
        int n;
        io_write(iwd_pkg::IWD_ARM_PORT, 16'hFFFF);
        wait_level(1'b0, n);
        check("fire F", 8'h01, 8'(n <= 2));
        wait_level(1'b1, n);
    endtask
    task automatic t_rearm_disarm();
        io_write(iwd_pkg::IWD_ARM_PORT, 16'hFFF0);
        check("secs 0", 8'h1E, 8'(secs_left_out));
        step(25);
        check("count", 8'h1C, 8'(secs_left_out));
        io_write(iwd_pkg::IWD_ARM_PORT, 16'h000C);
        check("rearm", 8'h06, 8'(secs_left_out));
        io_write(iwd_pkg::IWD_DISARM_PORT, 16'h1234);
        check("disarm", 8'h00, 8'(armed_out));
        step(100);
        check("no reset", 8'h01, 8'(sys_rst_n_out));
        io_write(16'h0442, 16'h0000);
        check("stray", 8'h00, 8'(armed_out));
    endtask
    task automatic t_mid_reset();
        io_write(iwd_pkg::IWD_ARM_PORT, 16'h000C);
        step(5);
        @(posedge clk_in);
        rst_n_in <= 1'b0;
        repeat (2) @(posedge clk_in);
        rst_n_in <= 1'b1;
        step(1);
        check("reset armed", 8'h00, 8'(armed_out));
        check("reset secs", 8'h00, 8'(secs_left_out));
        step(30);
        check("reset quiet", 8'h01, 8'(sys_rst_n_out));
    endtask
    task automatic summarize();
        if (n_mismatch == 0 && checks > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask
    initial begin
        step(1000);
        n_mismatch++;
        summarize();
    end
    initial begin
        repeat (16) @(posedge clk_in);
        rst_n_in <= 1'b1;
        step(2);
        t_expire();
        t_code_f();
        t_rearm_disarm();
        t_mid_reset();
        summarize();
    end
endmodule
`default_nettype wire
